// >>> rtl/dic_top.sv
// Purpose: interrupt status, mask, vector and address-triggered commands
// Assumes: bus strobes and event pulses come from logic on clk_i
// Notes: only the four input-change pins come from outside the clock
`timescale 1ns/1ns
`default_nettype none
`include "dic_consts.svh"

// Contract
// - some commands fire by bare address access
// - read of 0E starts the counter
// - counter-start read drives no data
// - write of 0E sets selected latch bits
// - output pins are inverted latch bits
// - active-low request for any enabled event
// - status/mask 05, masked 02, vector 0C
// - status bit layout, one means occurred
// - input change sets bit 7, capture read clears
// - break change sets bit; break reset clears
// - mode bit picks ready or full
// - ready mode: set on load, re-set after read
// - full mode: set when full, re-set on load
// - full mode: partial FIFO never signals
// - masked status is status AND mask
// - mask one enables, zero blocks
// - tx ready clears on write, sets on transfer
// - counter done sets bit 3, stop clears
module dic_top
  import dic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic rd_i,
  input wire logic wr_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // transmitter events, index 0 is channel a
  input wire logic [1:0] tx_enable_i,
  input wire logic [1:0] thr_write_i,
  input wire logic [1:0] tsr_load_i,
  // receiver events
  input wire logic [1:0] rx_fifo_mode_i,
  input wire logic [1:0] rx_load_i,
  input wire logic [1:0] rx_pop_i,
  input wire logic [1:0] rx_fifo_full_i,
  input wire logic [1:0] rx_not_empty_i,
  input wire logic [1:0] break_change_i,
  input wire logic [1:0] break_reset_cmd_i,
  // counter/timer
  input wire logic ctr_done_i,
  output logic ctr_start_o,
  output logic ctr_stop_o,
  // input change detection
  input wire logic [3:0] change_watch_inputs_i,
  input wire logic [3:0] aux_control_i,
  input wire logic input_change_capture_rd_i,
  // output port and interrupt
  output logic [7:0] output_port_latch_o,
  output logic [7:0] output_pins_n_o,
  output logic irq_n_out
);

  dic_byte_type interrupt_status_q;
  dic_byte_type interrupt_status_d;
  dic_byte_type interrupt_mask_q;
  dic_byte_type interrupt_vector_q;
  dic_byte_type output_port_latch_q;
  dic_byte_type masked_interrupt_status;
  dic_byte_type data_q;
  logic data_oe_q;
  logic irq_n_q;
  logic ctr_start_q;
  logic ctr_stop_q;
  dic_chan_type tx_enable_q;
  dic_chan_type rx_pop_q;
  dic_chan_type rx_load_q;
  logic [3:0] watch_meta_q;
  logic [3:0] watch_sync_q;
  logic [3:0] watch_prev_q;
  logic input_change;

  wire logic rd_set_cmd = rd_i && (addr_i == `DIC_ADDR_SET_CMD);
  wire logic rd_clr_cmd = rd_i && (addr_i == `DIC_ADDR_CLR_CMD);
  wire logic wr_set_cmd = wr_i && (addr_i == `DIC_ADDR_SET_CMD);
  wire logic wr_clr_cmd = wr_i && (addr_i == `DIC_ADDR_CLR_CMD);

  assign masked_interrupt_status = interrupt_status_q & interrupt_mask_q;

  // input pins cross in through two flops before the change compare
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      watch_meta_q <= 4'h0;
      watch_sync_q <= 4'h0;
      watch_prev_q <= 4'h0;
    end
    else
    begin
      watch_meta_q <= change_watch_inputs_i;
      watch_sync_q <= watch_meta_q;
      watch_prev_q <= watch_sync_q;
    end
  end

  // only inputs picked in the aux control nibble may raise the bit
  assign input_change = |((watch_sync_q ^ watch_prev_q) & aux_control_i);

  // event history for the set-again cases
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_enable_q <= 2'h0;
      rx_pop_q <= 2'h0;
      rx_load_q <= 2'h0;
    end
    else
    begin
      tx_enable_q <= tx_enable_i;
      rx_pop_q <= rx_pop_i;
      rx_load_q <= rx_load_i;
    end
  end

  // status next value, per channel then shared bits; set wins over clear
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      localparam int TX = `DIC_BIT_TXA + c * `DIC_CHAN_STRIDE;
      localparam int RX = TX + `DIC_OFS_RX;
      localparam int BK = TX + `DIC_OFS_BRK;
      logic tx_set;
      logic rx_set;
      // full flag is sampled a cycle after the load so it shows the new level
      assign tx_set = tsr_load_i[c] || (tx_enable_i[c] && !tx_enable_q[c]);
      assign rx_set = rx_fifo_mode_i[c] ?
        (rx_load_q[c] && rx_fifo_full_i[c]) :
        (rx_load_q[c] || (rx_pop_q[c] && rx_not_empty_i[c]));
      always_comb
      begin
        if (tx_set)
          interrupt_status_d[TX] = 1'b1;
        else if (thr_write_i[c] || !tx_enable_i[c])
          interrupt_status_d[TX] = 1'b0;
        else
          interrupt_status_d[TX] = interrupt_status_q[TX];
        if (rx_set)
          interrupt_status_d[RX] = 1'b1;
        else if (rx_pop_i[c])
          interrupt_status_d[RX] = 1'b0;
        else
          interrupt_status_d[RX] = interrupt_status_q[RX];
        if (break_change_i[c])
          interrupt_status_d[BK] = 1'b1;
        else if (break_reset_cmd_i[c])
          interrupt_status_d[BK] = 1'b0;
        else
          interrupt_status_d[BK] = interrupt_status_q[BK];
      end
    end
  endgenerate

  always_comb
  begin
    if (ctr_done_i)
      interrupt_status_d[`DIC_BIT_CTR] = 1'b1;
    else if (rd_clr_cmd)
      interrupt_status_d[`DIC_BIT_CTR] = 1'b0;
    else
      interrupt_status_d[`DIC_BIT_CTR] = interrupt_status_q[`DIC_BIT_CTR];
    if (input_change)
      interrupt_status_d[`DIC_BIT_IPC] = 1'b1;
    else if (input_change_capture_rd_i)
      interrupt_status_d[`DIC_BIT_IPC] = 1'b0;
    else
      interrupt_status_d[`DIC_BIT_IPC] = interrupt_status_q[`DIC_BIT_IPC];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      interrupt_status_q <= `DIC_RST_BYTE;
    else
      interrupt_status_q <= interrupt_status_d;
  end

  // mask and vector writes
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      interrupt_mask_q <= `DIC_RST_MASK;
      interrupt_vector_q <= `DIC_RST_VECTOR;
    end
    else if (wr_i)
    begin
      if (addr_i == `DIC_ADDR_MASK)
        interrupt_mask_q <= data_i;
      if (addr_i == `DIC_ADDR_VECTOR)
        interrupt_vector_q <= data_i;
    end
  end

  // address-triggered latch commands; a bit named by neither keeps its value
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      output_port_latch_q <= `DIC_RST_LATCH;
    else if (wr_set_cmd)
      output_port_latch_q <= output_port_latch_q | data_i;
    else if (wr_clr_cmd)
      output_port_latch_q <= output_port_latch_q & ~data_i;
  end

  assign output_port_latch_o = output_port_latch_q;
  assign output_pins_n_o = ~output_port_latch_q;

  // counter commands are one-cycle pulses to the counter/timer
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ctr_start_q <= 1'b0;
      ctr_stop_q <= 1'b0;
    end
    else
    begin
      ctr_start_q <= rd_set_cmd;
      ctr_stop_q <= rd_clr_cmd;
    end
  end

  assign ctr_start_o = ctr_start_q;
  assign ctr_stop_o = ctr_stop_q;

  // read data, registered; command addresses leave the bus undriven
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      data_q <= `DIC_RST_BYTE;
      data_oe_q <= 1'b0;
    end
    else
    begin
      data_oe_q <= rd_i && !rd_set_cmd && !rd_clr_cmd;
      if (rd_i)
      begin
        case (addr_i)
          `DIC_ADDR_MASKED_STATUS: data_q <= masked_interrupt_status;
          `DIC_ADDR_STATUS: data_q <= interrupt_status_q;
          `DIC_ADDR_VECTOR: data_q <= interrupt_vector_q;
          default: data_q <= `DIC_RST_BYTE;
        endcase
      end
    end
  end

  assign data_o = data_q;
  assign data_oe_o = data_oe_q;

  // the request follows the masked status, one flop late
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      irq_n_q <= 1'b1;
    else
      irq_n_q <= ~|masked_interrupt_status;
  end

  assign irq_n_out = irq_n_q;

  AST_START_PULSE:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_set_cmd |=> ctr_start_o && !data_oe_o)
    else $error("start read did not pulse the counter");

  AST_START_NO_DATA:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ctr_start_o |-> !data_oe_o)
    else $error("data driven during counter start read");

  AST_SET_BITS:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_set_cmd |=> output_port_latch_o ==
        ($past(output_port_latch_o) | $past(data_i)))
    else $error("set command changed wrong latch bits");

  AST_CLR_BITS:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_clr_cmd |=> output_port_latch_o ==
        ($past(output_port_latch_o) & ~$past(data_i)))
    else $error("clear command changed wrong latch bits");

  AST_PINS_INVERT:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      output_pins_n_o == ~output_port_latch_o)
    else $error("output pin not inverse of latch");

  AST_IRQ_FOLLOWS:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (|(interrupt_status_q & interrupt_mask_q)) |=> !irq_n_out)
    else $error("request not raised for masked status");

  AST_IRQ_RELEASE:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(irq_n_out) |-> $past(interrupt_status_q & interrupt_mask_q)
        == 8'h00)
    else $error("request released with masked status set");

  AST_MASKED_READ:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == `DIC_ADDR_MASKED_STATUS |=> data_oe_o &&
        data_o == ($past(interrupt_status_q) & $past(interrupt_mask_q)))
    else $error("masked status read wrong");

  AST_IPC_SET:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      input_change |=> interrupt_status_q[`DIC_BIT_IPC])
    else $error("input change not flagged");

  AST_BRK_HOLD:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      interrupt_status_q[6] && !break_reset_cmd_i[1] |=>
        interrupt_status_q[6])
    else $error("break change bit cleared without reset command");

  AST_FULL_ONLY:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rx_fifo_mode_i[1] && !rx_fifo_full_i[1] && !interrupt_status_q[5]
        |=> !interrupt_status_q[5])
    else $error("full-mode bit set on partial fifo");

  AST_CTR_CLEAR:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_clr_cmd && !ctr_done_i |=>
        !interrupt_status_q[`DIC_BIT_CTR] && ctr_stop_o)
    else $error("stop command did not clear counter bit");

  AST_TX_CLEAR:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
      thr_write_i[0] && !tsr_load_i[0] &&
        !(tx_enable_i[0] && !tx_enable_q[0]) |=> !interrupt_status_q[0])
    else $error("tx ready not cleared by holding write");

endmodule : dic_top
`default_nettype wire

// >>> inc/dic_consts.svh
// Purpose: constants of the serial interrupt and address command block
// Assumes: 4-bit register address, 8-bit data
// Notes: offsets are the device's own register addresses
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH
`define DIC_ADDR_MASKED_STATUS 4'h2
`define DIC_ADDR_STATUS 4'h5
`define DIC_ADDR_MASK 4'h5
`define DIC_ADDR_VECTOR 4'hc
`define DIC_ADDR_SET_CMD 4'he
`define DIC_ADDR_CLR_CMD 4'hf
`define DIC_RST_MASK 8'h00
`define DIC_RST_VECTOR 8'h0f
`define DIC_RST_LATCH 8'h00
`define DIC_RST_BYTE 8'h00
`define DIC_BIT_TXA 0
`define DIC_BIT_CTR 3
`define DIC_BIT_IPC 7
`define DIC_CHAN_STRIDE 4
`define DIC_OFS_RX 1
`define DIC_OFS_BRK 2
`endif

// >>> inc/dic_pkg.sv
// Purpose: shared types of the serial interrupt and address command block
// Assumes: nothing beyond the constants header
// Notes: widths are fixed
package dic_pkg;
  typedef logic [7:0] dic_byte_type;
  typedef logic [3:0] dic_addr_type;
  typedef logic [1:0] dic_chan_type;
endpackage : dic_pkg

// >>> testbench/dic_host_model.sv
// Purpose: host side of the register port
// Assumes: one strobe cycle per access
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module dic_host_model
(
  // clock
  input wire logic clk_i,
  // read side
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  // request side
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  output logic wr_o
);
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end

  // bare address access is the whole command, no command write needed
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic oe);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    rd_o = !w;
    wr_o = w;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
    oe = rdata_oe_i;
  endtask : access
endmodule : dic_host_model
`default_nettype wire

// >>> testbench/duart_interrupt_and_addr_cmds_tb.sv
// Purpose: self-checking bench of the interrupt and address command block
// Assumes: event inputs driven 1 ns after the rising edge
// Notes: each event pulse is followed by a three-cycle wait before the next access
`timescale 1ns/1ns
`default_nettype none
module duart_interrupt_and_addr_cmds_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] a;
  logic [7:0] d, q, lat, pn;
  logic rd, wr, oe, cs, cp, irq, capr;
  logic [1:0] txe = 2'b00, md = 2'b00, ff = 2'b00, ne = 2'b00;
  logic [12:0] pl = 13'h0;
  logic [3:0] pin = 4'h0, aux = 4'h0;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #5 clk_i = ~clk_i;

  dic_host_model host_u (.clk_i(clk_i), .rdata_i(q), .rdata_oe_i(oe),
    .addr_o(a), .wdata_o(d), .rd_o(rd), .wr_o(wr));

  dic_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(a),
    .data_i(d), .rd_i(rd), .wr_i(wr), .data_o(q), .data_oe_o(oe),
    .tx_enable_i(txe), .thr_write_i(pl[1:0]), .tsr_load_i(pl[3:2]),
    .rx_fifo_mode_i(md), .rx_load_i(pl[5:4]), .rx_pop_i(pl[7:6]),
    .rx_fifo_full_i(ff), .rx_not_empty_i(ne),
    .break_change_i(pl[9:8]), .break_reset_cmd_i(pl[11:10]),
    .ctr_done_i(pl[12]), .ctr_start_o(cs), .ctr_stop_o(cp),
    .change_watch_inputs_i(pin), .aux_control_i(aux),
    .input_change_capture_rd_i(capr), .output_port_latch_o(lat),
    .output_pins_n_o(pn), .irq_n_out(irq));

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdc(input logic [3:0] ad, input logic [7:0] e,
                     input logic eoe);
    logic [7:0] v;
    logic o;
    host_u.access(1'b0, ad, 8'h00, v, o);
    chk("read enable", {7'h0, eoe}, {7'h0, o});
    if (eoe)
      chk("read data", e, v);
  endtask : rdc

  task automatic wrc(input logic [3:0] ad, input logic [7:0] v);
    logic [7:0] x;
    logic o;
    host_u.access(1'b1, ad, v, x, o);
  endtask : wrc

  task automatic pulse(input logic [12:0] m);
    @(posedge clk_i);
    #1;
    pl = m;
    @(posedge clk_i);
    #1;
    pl = 13'h0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic irqc(input logic e);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask : irqc

  // ceiling well above the fewer than two hundred cycles the sequence needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    capr = 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    rdc(4'h5, 8'h00, 1'b1);
    rdc(4'hc, 8'h0f, 1'b1);
    rdc(4'h2, 8'h00, 1'b1);
    rdc(4'h7, 8'h00, 1'b1);
    wrc(4'hc, 8'ha5);
    rdc(4'hc, 8'ha5, 1'b1);
    rdc(4'he, 8'h00, 1'b0);
    chk("start", 8'h01, {7'h0, cs});
    rdc(4'hf, 8'h00, 1'b0);
    chk("stop", 8'h01, {7'h0, cp});
    chk("pins", 8'hff, pn);
    wrc(4'he, 8'h81);
    wrc(4'he, 8'h12);
    chk("latch", 8'h93, lat);
    chk("pins", 8'h6c, pn);
    wrc(4'hf, 8'h01);
    chk("latch", 8'h92, lat);
    txe = 2'b11;
    pulse(13'h0);
    rdc(4'h5, 8'h11, 1'b1);
    irqc(1'b1);
    wrc(4'h5, 8'h01);
    irqc(1'b0);
    rdc(4'h2, 8'h01, 1'b1);
    pulse(13'h0001);
    rdc(4'h5, 8'h10, 1'b1);
    irqc(1'b1);
    pulse(13'h0004);
    rdc(4'h5, 8'h11, 1'b1);
    txe = 2'b00;
    wrc(4'h5, 8'h4c);
    pulse(13'h0300);
    rdc(4'h5, 8'h44, 1'b1);
    pulse(13'h0800);
    rdc(4'h5, 8'h04, 1'b1);
    pulse(13'h1400);
    rdc(4'h5, 8'h08, 1'b1);
    irqc(1'b0);
    rdc(4'hf, 8'h00, 1'b0);
    rdc(4'h5, 8'h00, 1'b1);
    ne = 2'b11;
    pulse(13'h0030);
    rdc(4'h5, 8'h22, 1'b1);
    pulse(13'h0080);
    rdc(4'h5, 8'h22, 1'b1);
    ne = 2'b00;
    pulse(13'h00c0);
    rdc(4'h5, 8'h00, 1'b1);
    md = 2'b10;
    wrc(4'h5, 8'h20);
    pulse(13'h0020);
    rdc(4'h5, 8'h00, 1'b1);
    irqc(1'b1);
    ff = 2'b10;
    pulse(13'h0020);
    rdc(4'h5, 8'h20, 1'b1);
    irqc(1'b0);
    pulse(13'h0080);
    rdc(4'h5, 8'h00, 1'b1);
    pulse(13'h0020);
    rdc(4'h5, 8'h20, 1'b1);
    ff = 2'b00;
    pulse(13'h0080);
    aux = 4'hf;
    wrc(4'h5, 8'h80);
    pin = 4'h4;
    repeat (8) @(posedge clk_i);
    #1;
    rdc(4'h5, 8'h80, 1'b1);
    irqc(1'b0);
    capr = 1'b1;
    @(posedge clk_i);
    #1;
    capr = 1'b0;
    pulse(13'h0);
    rdc(4'h5, 8'h00, 1'b1);
    irqc(1'b1);
    finish_test();
  end
endmodule : duart_interrupt_and_addr_cmds_tb
`default_nettype wire
